// >>> include/tgc_pkg.sv
// Package for the timer gate control block: register map, fields, reset values, events.
package tgc_pkg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [11:0] GATE_CTRL_ADDR = 12'hF97;
    localparam logic [11:0] EVT_STATUS_ADDR = 12'hF98;
    localparam logic [11:0] EVT_CLEAR_ADDR = 12'hF99;
    localparam logic [11:0] EVT_ENABLE_ADDR = 12'hF9A;
    localparam logic [11:0] TIMER_CTRL_ADDR = 12'hF9B;
    localparam logic [11:0] COUNT_LO_ADDR = 12'hF9C;
    localparam logic [11:0] COUNT_HI_ADDR = 12'hF9D;

    // ------------------------------------------------------------
    // Gate control and timer control register fields
    // ------------------------------------------------------------
    localparam int GATE_ENABLE_BIT = 7;
    localparam int GATE_POLARITY_BIT = 6;
    localparam int GATE_TOGGLE_MODE_BIT = 5;
    localparam int GATE_SINGLE_PULSE_MODE_BIT = 4;
    localparam int PULSE_GO_DONE_BIT = 3;
    localparam int GATE_LEVEL_VIEW_BIT = 2;
    localparam int GATE_SOURCE_SELECT_LSB = 0;
    localparam int TIMER_ON_BIT = 0;

    // Gate source encodings
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_MATCH = 2'h1;
    localparam logic [1:0] SRC_CMP1 = 2'h2;
    localparam logic [1:0] SRC_CMP2 = 2'h3;

    // ------------------------------------------------------------
    // Event status bits
    // ------------------------------------------------------------
    localparam int EVT_DONE_BIT = 0;
    localparam int EVT_OVF_BIT = 1;
    localparam int EVT_GATE_RISE_BIT = 2;
    localparam int EVT_W = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GATE_CTRL_RST = 8'h00;
    localparam logic [2:0] EVT_RST = 3'h0;
    localparam logic [15:0] COUNT_RST = 16'h0000;

endpackage

// >>> rtl/tgc_top.sv
// Timer gate control: gate path, single-pulse acquisition, 16-bit count and register port.
//
// Behaviour
// - Gate enable is ignored while the timer is off; when on, it gates counting.
// - Polarity bit 1 counts while gate high, 0 counts while gate low.
// - Toggle mode bit enables toggle; clearing it clears the toggle flip-flop.
// - In toggle mode the flip-flop flips on every rising gate edge.
// - Single-pulse mode bit gives single-pulse logic control of the gate.
// - Go/done reads 1 while armed and waiting, 0 when finished or idle.
// - Clearing single-pulse mode clears go/done.
// - Gate level view shows the live gate, independent of gate enable.
// - Source select 11 cmp2, 10 cmp1, 01 timer match, 00 external pin.
// - Armed timer counts from next active edge; trailing edge clears go/done.
// - After completion no gate events increment until go/done set again.
// - Toggle and single-pulse together measure one full gate cycle.
`timescale 1ns/1ps
module tgc_top (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Gate sources
    input wire logic external_gate_pin,
    input wire logic match_timer_match,
    input wire logic cmp1_out,
    input wire logic cmp2_out,
    // Timer clock enable (one pulse per incrementing edge)
    input wire logic tick_en,
    // Outputs
    output logic [15:0] count_register,
    output logic count_inc,
    output logic irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic gate_enable_r;
    logic gate_polarity_r;
    logic gate_toggle_mode_r;
    logic gate_single_pulse_mode_r;
    logic pulse_go_done_r;
    logic [1:0] gate_source_select_r;
    logic timer_on_r;
    logic [2:0] evt_status_r;
    logic [2:0] evt_enable_r;
    logic toggle_ff_r;
    logic edge_ok_r;
    logic pol_gate_d_r;
    logic sp_run_r;
    logic sp_gate_d_r;
    logic [15:0] count_r;
    logic [7:0] rdata_r;
    logic inc_r;
    logic irq_r;

    logic src_gate;
    logic pol_gate;
    logic tog_gate;
    logic final_gate;
    logic count_now;
    logic gate_rise;
    logic sp_rise;
    logic sp_fall;
    logic wr_ctrl;
    logic arm_req;
    logic done_evt;
    logic ovf_evt;
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    logic [7:0] ctrl_view;

    assign wr_ctrl = reg_wr && (reg_addr == tgc_pkg::GATE_CTRL_ADDR);

    // ------------------------------------------------------------
    // Gate path
    // ------------------------------------------------------------
    always_comb begin
        case (gate_source_select_r)
            tgc_pkg::SRC_CMP2: src_gate = cmp2_out;
            tgc_pkg::SRC_CMP1: src_gate = cmp1_out;
            tgc_pkg::SRC_MATCH: src_gate = match_timer_match;
            default: src_gate = external_gate_pin;
        endcase
    end

    // Polarity folded first so that toggle and single pulse see an active-high gate
    assign pol_gate = gate_polarity_r ? src_gate : ~src_gate;
    assign gate_rise = pol_gate && !pol_gate_d_r && edge_ok_r;
    assign tog_gate = gate_toggle_mode_r ? toggle_ff_r : pol_gate;

    // Edge detection waits one cycle after reset, so a gate that is already
    // active then is not taken for a rising edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pol_gate_d_r <= 1'b0;
            edge_ok_r <= 1'b0;
        end else begin
            pol_gate_d_r <= pol_gate;
            edge_ok_r <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            toggle_ff_r <= 1'b0;
        end else if (!gate_toggle_mode_r) begin
            toggle_ff_r <= 1'b0;
        end else if (gate_rise) begin
            toggle_ff_r <= ~toggle_ff_r;
        end
    end

    // ------------------------------------------------------------
    // Single-pulse acquisition
    // ------------------------------------------------------------
    // With toggle on, the pulse seen here spans a full gate cycle
    assign sp_rise = tog_gate && !sp_gate_d_r;
    assign sp_fall = !tog_gate && sp_gate_d_r;
    assign done_evt = pulse_go_done_r && sp_run_r && sp_fall;
    assign arm_req = wr_ctrl && reg_wdata[tgc_pkg::PULSE_GO_DONE_BIT]
        && reg_wdata[tgc_pkg::GATE_SINGLE_PULSE_MODE_BIT];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sp_gate_d_r <= 1'b0;
        end else begin
            sp_gate_d_r <= tog_gate;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pulse_go_done_r <= 1'b0;
            sp_run_r <= 1'b0;
        end else if (wr_ctrl && !reg_wdata[tgc_pkg::GATE_SINGLE_PULSE_MODE_BIT]) begin
            pulse_go_done_r <= 1'b0;
            sp_run_r <= 1'b0;
        end else if (arm_req && !pulse_go_done_r) begin
            pulse_go_done_r <= 1'b1;
            sp_run_r <= 1'b0;
        end else if (done_evt) begin
            pulse_go_done_r <= 1'b0;
            sp_run_r <= 1'b0;
        end else if (pulse_go_done_r && sp_rise) begin
            sp_run_r <= 1'b1;
        end
    end

    // Only a pulse whose leading edge came after arming is passed on
    always_comb begin
        if (gate_single_pulse_mode_r) begin
            final_gate = pulse_go_done_r && (sp_run_r || sp_rise) && tog_gate;
        end else begin
            final_gate = tog_gate;
        end
    end

    // ------------------------------------------------------------
    // Count enable and counter
    // ------------------------------------------------------------
    always_comb begin
        if (!timer_on_r) begin
            count_now = 1'b0;
        end else if (gate_enable_r) begin
            count_now = tick_en && final_gate;
        end else begin
            count_now = tick_en;
        end
    end

    assign ovf_evt = count_now && (count_r == 16'hFFFF);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_r <= tgc_pkg::COUNT_RST;
            inc_r <= 1'b0;
        end else begin
            inc_r <= count_now;
            if (reg_wr && reg_addr == tgc_pkg::COUNT_LO_ADDR) begin
                count_r[7:0] <= reg_wdata;
            end else if (reg_wr && reg_addr == tgc_pkg::COUNT_HI_ADDR) begin
                count_r[15:8] <= reg_wdata;
            end else if (count_now) begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gate_enable_r <= tgc_pkg::GATE_CTRL_RST[7];
            gate_polarity_r <= tgc_pkg::GATE_CTRL_RST[6];
            gate_toggle_mode_r <= tgc_pkg::GATE_CTRL_RST[5];
            gate_single_pulse_mode_r <= tgc_pkg::GATE_CTRL_RST[4];
            gate_source_select_r <= tgc_pkg::GATE_CTRL_RST[1:0];
        end else if (wr_ctrl) begin
            gate_enable_r <= reg_wdata[tgc_pkg::GATE_ENABLE_BIT];
            gate_polarity_r <= reg_wdata[tgc_pkg::GATE_POLARITY_BIT];
            gate_toggle_mode_r <= reg_wdata[tgc_pkg::GATE_TOGGLE_MODE_BIT];
            gate_single_pulse_mode_r <= reg_wdata[tgc_pkg::GATE_SINGLE_PULSE_MODE_BIT];
            gate_source_select_r <= reg_wdata[1:0];
        end
    end

    // Recommended order: gate register first, then timer on
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timer_on_r <= 1'b0;
        end else if (reg_wr && reg_addr == tgc_pkg::TIMER_CTRL_ADDR) begin
            timer_on_r <= reg_wdata[tgc_pkg::TIMER_ON_BIT];
        end
    end

    // ------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------
    assign evt_set = {gate_rise, ovf_evt, done_evt};
    assign evt_clr = (reg_wr && reg_addr == tgc_pkg::EVT_CLEAR_ADDR) ? reg_wdata[2:0] : 3'h0;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_status_r <= tgc_pkg::EVT_RST;
            evt_enable_r <= tgc_pkg::EVT_RST;
            irq_r <= 1'b0;
        end else begin
            // A set in the same cycle as its clear wins
            evt_status_r <= (evt_status_r & ~evt_clr) | evt_set;
            if (reg_wr && reg_addr == tgc_pkg::EVT_ENABLE_ADDR) begin
                evt_enable_r <= reg_wdata[2:0];
            end
            irq_r <= |(((evt_status_r & ~evt_clr) | evt_set) & evt_enable_r);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign ctrl_view = {gate_enable_r, gate_polarity_r, gate_toggle_mode_r,
        gate_single_pulse_mode_r, pulse_go_done_r, final_gate, gate_source_select_r};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                tgc_pkg::GATE_CTRL_ADDR: rdata_r <= ctrl_view;
                tgc_pkg::EVT_STATUS_ADDR: rdata_r <= {5'h00, evt_status_r};
                tgc_pkg::EVT_ENABLE_ADDR: rdata_r <= {5'h00, evt_enable_r};
                tgc_pkg::TIMER_CTRL_ADDR: rdata_r <= {7'h00, timer_on_r};
                tgc_pkg::COUNT_LO_ADDR: rdata_r <= count_r[7:0];
                tgc_pkg::COUNT_HI_ADDR: rdata_r <= count_r[15:8];
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign count_register = count_r;
    assign count_inc = inc_r;
    assign irq = irq_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_off_no_count: assert property (@(posedge ref_clk) disable iff (rst)
        !timer_on_r |=> !inc_r)
        else $error("count advanced while timer off");

    a_ungated_counts: assert property (@(posedge ref_clk) disable iff (rst)
        (timer_on_r && !gate_enable_r && tick_en) |=> inc_r)
        else $error("ungated tick did not count");

    a_polarity_block: assert property (@(posedge ref_clk) disable iff (rst)
        (timer_on_r && gate_enable_r && !gate_toggle_mode_r && !gate_single_pulse_mode_r
        && !pol_gate) |=> !inc_r)
        else $error("counted on inactive gate level");

    a_toggle_clear: assert property (@(posedge ref_clk) disable iff (rst)
        !gate_toggle_mode_r |=> !toggle_ff_r)
        else $error("toggle flip-flop not cleared");

    a_toggle_flip: assert property (@(posedge ref_clk) disable iff (rst)
        (gate_toggle_mode_r && gate_rise && !wr_ctrl) |=> (toggle_ff_r != $past(toggle_ff_r)))
        else $error("toggle did not flip on rising edge");

    a_spm_clear_done: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !reg_wdata[tgc_pkg::GATE_SINGLE_PULSE_MODE_BIT]) |=> !pulse_go_done_r)
        else $error("go/done survived single-pulse clear");

    a_trailing_done: assert property (@(posedge ref_clk) disable iff (rst)
        (done_evt && !arm_req) |=> (!pulse_go_done_r && evt_status_r[tgc_pkg::EVT_DONE_BIT]))
        else $error("trailing edge did not finish acquisition");

    a_blocked_after: assert property (@(posedge ref_clk) disable iff (rst)
        (gate_single_pulse_mode_r && gate_enable_r && !pulse_go_done_r) |=> !inc_r)
        else $error("counted after acquisition completed");

    a_source_map: assert property (@(posedge ref_clk) disable iff (rst)
        (timer_on_r && gate_enable_r && !gate_toggle_mode_r && !gate_single_pulse_mode_r
        && gate_source_select_r == tgc_pkg::SRC_CMP2 && tick_en
        && (cmp2_out == gate_polarity_r)) |=> inc_r)
        else $error("comparator 2 gate did not count");

    a_source_pin: assert property (@(posedge ref_clk) disable iff (rst)
        (timer_on_r && gate_enable_r && !gate_toggle_mode_r && !gate_single_pulse_mode_r
        && gate_source_select_r == tgc_pkg::SRC_PIN
        && (external_gate_pin != gate_polarity_r)) |=> !inc_r)
        else $error("counted on inactive gate pin");

    a_go_needs_spm: assert property (@(posedge ref_clk) disable iff (rst)
        pulse_go_done_r |-> gate_single_pulse_mode_r)
        else $error("go/done set without single-pulse mode");

    a_toggle_hold: assert property (@(posedge ref_clk) disable iff (rst)
        (gate_toggle_mode_r && !gate_rise) |=> $stable(toggle_ff_r))
        else $error("toggle flip-flop moved without a rising edge");

    a_count_step: assert property (@(posedge ref_clk) disable iff (rst)
        (count_now && !reg_wr) |=> (count_r == $past(count_r) + 16'h0001))
        else $error("count did not advance by one");

    a_reset_clear: assert property (@(posedge ref_clk)
        rst |=> (!gate_enable_r && !gate_polarity_r && !gate_toggle_mode_r
        && !gate_single_pulse_mode_r && !pulse_go_done_r && !timer_on_r
        && gate_source_select_r == 2'h0 && count_r == tgc_pkg::COUNT_RST))
        else $error("control bits not cleared by reset");

    a_level_view: assert property (@(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == tgc_pkg::GATE_CTRL_ADDR && !gate_toggle_mode_r
        && !gate_single_pulse_mode_r) |=> (reg_rdata[tgc_pkg::GATE_LEVEL_VIEW_BIT]
        == ($past(src_gate) == $past(gate_polarity_r))))
        else $error("gate level view does not follow the gate");

endmodule

// >>> verif/tgc_gate_model.sv
// Model of the gate sources and the timer clock that face the gate control block.
`timescale 1ns/1ps
module tgc_gate_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Scenario control
    input wire logic [1:0] sel,
    input wire logic lvl,
    // Gate sources and timer clock
    output logic external_gate_pin,
    output logic match_timer_match,
    output logic cmp1_out,
    output logic cmp2_out,
    output logic tick_en
);
    // Unselected sources churn on a period of 6, unrelated to the 2-cycle tick,
    // so a wrong source select shows up as stray counts
    logic [1:0] phase_r;
    logic churn_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_r <= 2'h0;
            churn_r <= 1'b0;
            tick_en <= 1'b0;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            churn_r <= (phase_r == 2'h2) ? ~churn_r : churn_r;
            tick_en <= ~tick_en;
        end
    end
    assign external_gate_pin = (sel == 2'h0) ? lvl : churn_r;
    assign match_timer_match = (sel == 2'h1) ? lvl : ~churn_r;
    assign cmp1_out = (sel == 2'h2) ? lvl : churn_r;
    assign cmp2_out = (sel == 2'h3) ? lvl : ~churn_r;
endmodule

// >>> verif/testbench.sv
// Self-checking testbench for the timer gate control block.
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] sel = 2'h0;
    logic lvl = 1'b0;
    logic pin, mat, c1, c2, tick_en, count_inc, irq;
    logic [15:0] count_register;
    logic [7:0] d;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    tgc_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_gate_pin(pin),
        .match_timer_match(mat), .cmp1_out(c1), .cmp2_out(c2), .tick_en(tick_en),
        .count_register(count_register), .count_inc(count_inc), .irq(irq));
    tgc_gate_model u_model (.ref_clk(ref_clk), .rst(rst), .sel(sel), .lvl(lvl),
        .external_gate_pin(pin), .match_timer_match(mat), .cmp1_out(c1), .cmp2_out(c2),
        .tick_en(tick_en));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Lets the gate settle, then judges whether the count moves over 16 cycles
    task automatic moves(input logic exp);
        logic [15:0] snap;
        logic seen;
        run(4);
        snap = count_register;
        seen = 1'b0;
        repeat (16) begin
            run(1);
            seen = seen | (count_inc === 1'b1);
        end
        chk({15'h0, count_register !== snap}, {15'h0, exp});
        chk({15'h0, seen}, {15'h0, exp});
    endtask
    task automatic pulse();
        lvl <= 1'b1;
        run(4);
        lvl <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({8'h00, d & 8'hFB}, 16'h0000);
        chk({15'h0, d[2]}, 16'h0001);
        rd(tgc_pkg::TIMER_CTRL_ADDR, d);
        chk({8'h00, d}, 16'h0000);
        rd(12'h123, d);
        chk({8'h00, d}, 16'h0000);
        chk(count_register, tgc_pkg::COUNT_RST);
        $display("test reset done");
    endtask
    task automatic t_off();
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'h80);
        moves(1'b0);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'h00);
        moves(1'b0);
        $display("test timer off done");
    endtask
    task automatic t_sources();
        wr(tgc_pkg::TIMER_CTRL_ADDR, 8'h01);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                for (int l = 0; l < 2; l++) begin
                    sel <= s[1:0];
                    lvl <= l[0];
                    wr(tgc_pkg::GATE_CTRL_ADDR, {1'b1, p[0], 4'h0, s[1:0]});
                    moves(l == p);
                    rd(tgc_pkg::GATE_CTRL_ADDR, d);
                    chk({15'h0, d[2]}, {15'h0, l == p});
                    wr(tgc_pkg::GATE_CTRL_ADDR, {1'b0, p[0], 4'h0, s[1:0]});
                    moves(1'b1);
                    rd(tgc_pkg::GATE_CTRL_ADDR, d);
                    chk({15'h0, d[2]}, {15'h0, l == p});
                end
            end
        end
        $display("test sources done");
    endtask
    task automatic t_single();
        sel <= 2'h0;
        lvl <= 1'b0;
        wr(tgc_pkg::EVT_ENABLE_ADDR, 8'h01);
        wr(tgc_pkg::EVT_CLEAR_ADDR, 8'h07);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hD8);
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({15'h0, d[3]}, 16'h0001);
        moves(1'b0);
        lvl <= 1'b1;
        moves(1'b1);
        lvl <= 1'b0;
        run(3);
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({15'h0, d[3]}, 16'h0000);
        // Done plus the gate rising edge of the captured pulse
        rd(tgc_pkg::EVT_STATUS_ADDR, d);
        chk({8'h00, d}, 16'h0005);
        chk({15'h0, irq}, 16'h0001);
        lvl <= 1'b1;
        moves(1'b0);
        lvl <= 1'b0;
        wr(tgc_pkg::EVT_CLEAR_ADDR, 8'h01);
        run(2);
        chk({15'h0, irq}, 16'h0000);
        // Only done was cleared; the second pulse's rising edge stays sticky
        rd(tgc_pkg::EVT_STATUS_ADDR, d);
        chk({8'h00, d}, 16'h0004);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hD8);
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({15'h0, d[3]}, 16'h0001);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hC8);
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({15'h0, d[3]}, 16'h0000);
        $display("test single pulse done");
    endtask
    task automatic t_toggle();
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hE0);
        moves(1'b0);
        pulse();
        moves(1'b1);
        pulse();
        moves(1'b0);
        pulse();
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hC0);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hE0);
        moves(1'b0);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'hF8);
        pulse();
        moves(1'b1);
        pulse();
        moves(1'b0);
        pulse();
        moves(1'b0);
        rd(tgc_pkg::GATE_CTRL_ADDR, d);
        chk({15'h0, d[3]}, 16'h0000);
        $display("test toggle done");
    endtask
    task automatic t_count();
        wr(tgc_pkg::TIMER_CTRL_ADDR, 8'h00);
        wr(tgc_pkg::GATE_CTRL_ADDR, 8'h00);
        wr(tgc_pkg::EVT_CLEAR_ADDR, 8'h07);
        wr(tgc_pkg::EVT_ENABLE_ADDR, 8'h02);
        wr(tgc_pkg::COUNT_LO_ADDR, 8'hFF);
        wr(tgc_pkg::COUNT_HI_ADDR, 8'hFF);
        rd(tgc_pkg::COUNT_LO_ADDR, d);
        chk({8'h00, d}, 16'h00FF);
        rd(tgc_pkg::COUNT_HI_ADDR, d);
        chk({8'h00, d}, 16'h00FF);
        rd(tgc_pkg::EVT_ENABLE_ADDR, d);
        chk({8'h00, d}, 16'h0002);
        chk(count_register, 16'hFFFF);
        // Two cycles on hold exactly one tick of the model's timer clock
        wr(tgc_pkg::TIMER_CTRL_ADDR, 8'h01);
        wr(tgc_pkg::TIMER_CTRL_ADDR, 8'h00);
        run(2);
        chk(count_register, 16'h0000);
        rd(tgc_pkg::EVT_STATUS_ADDR, d);
        chk({8'h00, d}, 16'h0002);
        chk({15'h0, irq}, 16'h0001);
        wr(tgc_pkg::EVT_CLEAR_ADDR, 8'h02);
        run(2);
        chk({15'h0, irq}, 16'h0000);
        rd(tgc_pkg::EVT_STATUS_ADDR, d);
        chk({8'h00, d}, 16'h0000);
        $display("test count done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            $display("FAIL at %0t: timeout after %h cycles", $time, cyc);
            end_of_test();
        end
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_off();
        t_sources();
        t_single();
        t_toggle();
        t_count();
        end_of_test();
    end
endmodule
